// ### core/debug_port_pkg.sv
// Shared constants and types for the combined wire/JTAG debug port
package debug_port_pkg;
   localparam int IR_W = 4;
   localparam logic [3:0] IR_BYPASS = 4'hF;
   localparam logic [3:0] IR_IDCODE = 4'hE;
   localparam logic [3:0] IR_DPACC = 4'hA;
   localparam logic [3:0] IR_APACC = 4'hB;
   localparam logic [3:0] IR_CAPT = 4'h1;
   // Identity values are arbitrary
   localparam logic [31:0] TEST_IDCODE = 32'h0000_1001;
   localparam logic [31:0] CPU_IDCODE = 32'h0000_2001;
   localparam int ACC_W = 35;
   localparam int ACC_RNW = 0;
   localparam int ACC_A_LO = 1;
   localparam int ACC_D_LO = 3;
   localparam logic [2:0] ACK_OK = 3'h2;
   localparam logic [2:0] ACK_WAIT = 3'h1;
   localparam logic [1:0] AP_ADDR = 2'h0;
   localparam logic [1:0] AP_DATA = 2'h1;
   localparam logic [1:0] AP_CTRL = 2'h2;
   localparam logic [1:0] AP_STAT = 2'h3;
   localparam int CTRL_HALT = 0;
   localparam int CTRL_STEP = 1;
   localparam logic [15:0] SEQ_TO_WIRE = 16'hE79E;
   localparam logic [15:0] SEQ_TO_JTAG = 16'hE73C;
   localparam logic [5:0] SEL_ONES = 6'h32;
   localparam logic [3:0] SEQ_LAST = 4'hF;
   localparam int SYNC_N = 3;

   typedef enum logic [15:0] {
      S_TLR = 16'h0001, S_RTI = 16'h0002, S_SEL_DR = 16'h0004,
      S_CAP_DR = 16'h0008, S_SH_DR = 16'h0010, S_EX1_DR = 16'h0020,
      S_PA_DR = 16'h0040, S_EX2_DR = 16'h0080, S_UPD_DR = 16'h0100,
      S_SEL_IR = 16'h0200, S_CAP_IR = 16'h0400, S_SH_IR = 16'h0800,
      S_EX1_IR = 16'h1000, S_PA_IR = 16'h2000, S_EX2_IR = 16'h4000,
      S_UPD_IR = 16'h8000
   } tap_state_t;

   typedef struct packed {
      logic tlr;
      logic cap_ir;
      logic sh_ir;
      logic upd_ir;
      logic cap_dr;
      logic sh_dr;
      logic upd_dr;
   } tap_flags_t;

   typedef enum logic [1:0] {
      OP_RD = 2'h0, OP_WR = 2'h1, OP_CTRL = 2'h2, OP_STAT = 2'h3
   } op_t;

   typedef struct packed {
      op_t op;
      logic [31:0] addr;
      logic [31:0] data;
   } xfer_t;

   typedef struct packed {
      logic write;
      logic [31:0] addr;
      logic [31:0] wdata;
   } bus_cmd_t;

   typedef enum logic [1:0] {M_IDLE = 2'b01, M_BUS = 2'b10} mstate_t;
endpackage

// ### core/tap_fsm.sv
// Sixteen-state test access port controller
`timescale 1ns/1ps
module tap_fsm
   import debug_port_pkg::*;
(
   input wire logic tck,
   input wire logic rst,
   input wire logic tms,
   output tap_flags_t flags
);
   tap_state_t st_q;
   tap_state_t st_d;

   always_comb begin
      case (st_q)
         S_TLR: st_d = tms ? S_TLR : S_RTI;
         S_RTI: st_d = tms ? S_SEL_DR : S_RTI;
         S_SEL_DR: st_d = tms ? S_SEL_IR : S_CAP_DR;
         S_CAP_DR: st_d = tms ? S_EX1_DR : S_SH_DR;
         S_SH_DR: st_d = tms ? S_EX1_DR : S_SH_DR;
         S_EX1_DR: st_d = tms ? S_UPD_DR : S_PA_DR;
         S_PA_DR: st_d = tms ? S_EX2_DR : S_PA_DR;
         S_EX2_DR: st_d = tms ? S_UPD_DR : S_SH_DR;
         S_UPD_DR: st_d = tms ? S_SEL_DR : S_RTI;
         S_SEL_IR: st_d = tms ? S_TLR : S_CAP_IR;
         S_CAP_IR: st_d = tms ? S_EX1_IR : S_SH_IR;
         S_SH_IR: st_d = tms ? S_EX1_IR : S_SH_IR;
         S_EX1_IR: st_d = tms ? S_UPD_IR : S_PA_IR;
         S_PA_IR: st_d = tms ? S_EX2_IR : S_PA_IR;
         S_EX2_IR: st_d = tms ? S_UPD_IR : S_SH_IR;
         S_UPD_IR: st_d = tms ? S_SEL_DR : S_RTI;
         default: st_d = S_TLR;
      endcase
   end

   always_ff @(posedge tck) begin
      if (rst) begin
         st_q <= S_TLR;
      end else begin
         st_q <= st_d;
      end
   end

   assign flags.tlr = (st_q == S_TLR);
   assign flags.cap_ir = (st_q == S_CAP_IR);
   assign flags.sh_ir = (st_q == S_SH_IR);
   assign flags.upd_ir = (st_q == S_UPD_IR);
   assign flags.cap_dr = (st_q == S_CAP_DR);
   assign flags.sh_dr = (st_q == S_SH_DR);
   assign flags.upd_dr = (st_q == S_UPD_DR);
endmodule

// ### core/swj_debug_tap_chain.sv
// Combined wire/JTAG debug port with two chained TAPs and bus access
`timescale 1ns/1ps
module swj_debug_tap_chain
   import debug_port_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic jtag_clock_pin,
   input wire logic jtag_mode_select_pin,
   output logic jtag_mode_select_out,
   output logic jtag_mode_select_oe,
   input wire logic jtag_data_in_pin,
   output logic jtag_data_out_pin,
   output logic jtag_data_out_oe,
   input wire logic jtag_reset_n_pin,
   output logic bus_valid,
   output bus_cmd_t bus_cmd,
   input wire logic bus_ack,
   input wire logic [31:0] bus_rdata,
   input wire logic cpu_halted,
   output logic cpu_halt_req,
   output logic cpu_step,
   output logic wire_mode
);
   // Link clock domain: resets, ack crossing, mode detect
   logic [SYNC_N-1:0][1:0] rsy_q, rsy_d;
   logic [1:0] rlvl_q, rlvl_d, ragree;
   logic [SYNC_N-1:0] ak_q, ak_d;
   logic aklvl_q, aklvl_d;
   logic [5:0] ones_q, ones_d;
   logic [15:0] hist_q, hist_d;
   logic [3:0] cnt_q, cnt_d;
   logic wire_q, wire_d;
   logic tck_rst, hs_rst, tms, tdi, busy;
   logic req_q, req_d, ack_tgl_q, ack_tgl_d;

   assign tms = jtag_mode_select_pin;
   assign tdi = jtag_data_in_pin;
   assign tck_rst = |rlvl_q;
   assign hs_rst = rlvl_q[0];
   assign busy = req_q ^ aklvl_q;

   always_comb begin
      rsy_d = {rsy_q[1:0], {~jtag_reset_n_pin, sys_rst}};
      ragree = ~(rsy_q[1] ^ rsy_q[2]);
      rlvl_d = (ragree & rsy_q[2]) | (~ragree & rlvl_q);
      ak_d = {ak_q[1:0], ack_tgl_q};
      aklvl_d = (ak_q[1] == ak_q[2]) ? ak_q[2] : aklvl_q;
      ones_d = tms ? ((ones_q == SEL_ONES) ? ones_q : ones_q + 6'h01)
                   : 6'h00;
      hist_d = hist_q;
      cnt_d = cnt_q;
      wire_d = wire_q;
      if (cnt_q != 4'h0 || (!tms && ones_q == SEL_ONES)) begin
         hist_d = {tms, hist_q[15:1]};
         cnt_d = cnt_q + 4'h1;
         if (cnt_q == SEQ_LAST) begin
            if (hist_d == SEQ_TO_WIRE) begin
               wire_d = 1'b1;
            end else if (hist_d == SEQ_TO_JTAG) begin
               wire_d = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge jtag_clock_pin) begin
      rsy_q <= rsy_d;
      rlvl_q <= rlvl_d;
      ak_q <= ak_d;
      aklvl_q <= aklvl_d;
      if (tck_rst) begin
         ones_q <= 6'h00;
         hist_q <= 16'h0000;
         cnt_q <= 4'h0;
         wire_q <= 1'b0;
      end else begin
         ones_q <= ones_d;
         hist_q <= hist_d;
         cnt_q <= cnt_d;
         wire_q <= wire_d;
      end
   end

   // Test TAP, first in the chain
   tap_flags_t tf;
   logic tms_test, test_so;
   logic [IR_W-1:0] tir_q, tir_d, tirs_q, tirs_d;
   logic [31:0] tdr_q, tdr_d;

   assign tms_test = wire_q | tms;

   tap_fsm u_test_tap (
      .tck(jtag_clock_pin),
      .rst(tck_rst),
      .tms(tms_test),
      .flags(tf)
   );

   always_comb begin
      tir_d = tir_q;
      tirs_d = tirs_q;
      tdr_d = tdr_q;
      if (tf.tlr) begin
         tir_d = IR_IDCODE;
      end
      if (tf.cap_ir) begin
         tirs_d = IR_CAPT;
      end
      if (tf.sh_ir) begin
         tirs_d = {tdi, tirs_q[IR_W-1:1]};
      end
      if (tf.upd_ir) begin
         tir_d = tirs_q;
      end
      if (tf.cap_dr) begin
         tdr_d = (tir_q == IR_IDCODE) ? TEST_IDCODE : 32'h0000_0000;
      end
      if (tf.sh_dr) begin
         if (tir_q == IR_IDCODE) begin
            tdr_d = {tdi, tdr_q[31:1]};
         end else begin
            tdr_d = {tdr_q[31:1], tdi};
         end
      end
   end

   // test TAP output feeds processor TAP
   assign test_so = tf.sh_ir ? tirs_q[0] : tdr_q[0];

   always_ff @(posedge jtag_clock_pin) begin
      if (tck_rst) begin
         tir_q <= IR_IDCODE;
         tirs_q <= IR_CAPT;
         tdr_q <= 32'h0000_0000;
      end else begin
         tir_q <= tir_d;
         tirs_q <= tirs_d;
         tdr_q <= tdr_d;
      end
   end

   // Processor TAP, last in the chain, with access port requests
   tap_flags_t pf;
   logic [IR_W-1:0] pir_q, pir_d, pirs_q, pirs_d;
   logic [ACC_W-1:0] pdr_q, pdr_d;
   logic [31:0] tar_q, tar_d, upd_data;
   logic [1:0] upd_a;
   logic wait_q, wait_d;
   xfer_t xfer_q, xfer_d;
   logic [2:0] ack_code;
   logic [31:0] result_q;

   tap_fsm u_cpu_tap (
      .tck(jtag_clock_pin),
      .rst(tck_rst),
      .tms(tms),
      .flags(pf)
   );

   assign ack_code = busy ? ACK_WAIT : ACK_OK;
   assign upd_data = pdr_q[ACC_D_LO +: 32];
   assign upd_a = pdr_q[ACC_A_LO +: 2];

   always_comb begin
      pir_d = pir_q;
      pirs_d = pirs_q;
      pdr_d = pdr_q;
      tar_d = tar_q;
      wait_d = wait_q;
      req_d = req_q;
      xfer_d = xfer_q;
      // both TAPs wake in IDCODE, not BYPASS
      if (pf.tlr) begin
         pir_d = IR_IDCODE;
      end
      if (pf.cap_ir) begin
         pirs_d = IR_CAPT;
      end
      if (pf.sh_ir) begin
         pirs_d = {test_so, pirs_q[IR_W-1:1]};
      end
      if (pf.upd_ir) begin
         pir_d = pirs_q;
      end
      if (pf.cap_dr) begin
         wait_d = busy;
         case (pir_q)
            IR_IDCODE: pdr_d = {3'h0, CPU_IDCODE};
            IR_DPACC: pdr_d = {30'h0, wire_q, busy, ack_code};
            IR_APACC: pdr_d = {busy ? 32'h0 : result_q, ack_code};
            default: pdr_d = '0;
         endcase
      end
      if (pf.sh_dr) begin
         case (pir_q)
            IR_IDCODE: pdr_d[31:0] = {test_so, pdr_q[31:1]};
            IR_DPACC, IR_APACC: pdr_d = {test_so, pdr_q[ACC_W-1:1]};
            default: pdr_d[0] = test_so;
         endcase
      end
      // access port requests toward the bus
      if (pf.upd_dr && pir_q == IR_APACC && !wait_q) begin
         case (upd_a)
            AP_ADDR: begin
               if (!pdr_q[ACC_RNW]) begin
                  tar_d = upd_data;
               end
            end
            AP_DATA: begin
               xfer_d.op = pdr_q[ACC_RNW] ? OP_RD : OP_WR;
               req_d = ~req_q;
            end
            AP_CTRL: begin
               xfer_d.op = OP_CTRL;
               req_d = ~req_q;
            end
            AP_STAT: begin
               xfer_d.op = OP_STAT;
               req_d = ~req_q;
            end
            default: req_d = req_q;
         endcase
         xfer_d.addr = tar_q;
         xfer_d.data = upd_data;
      end
   end

   always_ff @(posedge jtag_clock_pin) begin
      if (tck_rst) begin
         pir_q <= IR_IDCODE;
         pirs_q <= IR_CAPT;
         pdr_q <= '0;
         wait_q <= 1'b0;
      end else begin
         pir_q <= pir_d;
         pirs_q <= pirs_d;
         pdr_q <= pdr_d;
         wait_q <= wait_d;
      end
      if (hs_rst) begin
         tar_q <= 32'h0000_0000;
         req_q <= 1'b0;
         xfer_q <= '0;
      end else begin
         tar_q <= tar_d;
         req_q <= req_d;
         xfer_q <= xfer_d;
      end
   end

   // data out changes on the falling clock edge
   logic tdo_q, tdo_d, oe_q, oe_d;

   always_comb begin
      tdo_d = pf.sh_ir ? pirs_q[0] : pdr_q[0];
      oe_d = pf.sh_ir | pf.sh_dr;
   end

   always_ff @(negedge jtag_clock_pin) begin
      if (tck_rst) begin
         tdo_q <= 1'b0;
         oe_q <= 1'b0;
      end else begin
         tdo_q <= tdo_d;
         oe_q <= oe_d;
      end
   end

   assign jtag_data_out_pin = tdo_q;
   assign jtag_data_out_oe = oe_q;
   assign jtag_mode_select_out = 1'b0;
   assign jtag_mode_select_oe = 1'b0;

   // System clock domain: access port bus master
   logic [SYNC_N-1:0] rq_q, rq_d, ws_q, ws_d;
   logic rqlvl_q, rqlvl_d, seen_q, seen_d, wlvl_q, wlvl_d;
   logic valid_q, valid_d;
   logic halt_q, halt_d, step_q, step_d;
   bus_cmd_t cmd_q, cmd_d;
   logic [31:0] result_d;
   mstate_t mst_q, mst_d;

   always_comb begin
      rq_d = {rq_q[1:0], req_q};
      rqlvl_d = (rq_q[1] == rq_q[2]) ? rq_q[2] : rqlvl_q;
      ws_d = {ws_q[1:0], wire_q};
      wlvl_d = (ws_q[1] == ws_q[2]) ? ws_q[2] : wlvl_q;
      seen_d = seen_q;
      ack_tgl_d = ack_tgl_q;
      valid_d = valid_q;
      halt_d = halt_q;
      step_d = 1'b0;
      cmd_d = cmd_q;
      result_d = result_q;
      mst_d = mst_q;
      case (mst_q)
         M_IDLE: begin
            if (rqlvl_q != seen_q) begin
               seen_d = rqlvl_q;
               case (xfer_q.op)
                  OP_RD, OP_WR: begin
                     valid_d = 1'b1;
                     cmd_d.write = (xfer_q.op == OP_WR);
                     cmd_d.addr = xfer_q.addr;
                     cmd_d.wdata = xfer_q.data;
                     mst_d = M_BUS;
                  end
                  OP_CTRL: begin
                     halt_d = xfer_q.data[CTRL_HALT];
                     step_d = xfer_q.data[CTRL_STEP];
                     ack_tgl_d = ~ack_tgl_q;
                  end
                  default: begin
                     result_d = {31'h0, cpu_halted};
                     ack_tgl_d = ~ack_tgl_q;
                  end
               endcase
            end
         end
         M_BUS: begin
            if (bus_ack) begin
               valid_d = 1'b0;
               if (!cmd_q.write) begin
                  result_d = bus_rdata;
               end
               ack_tgl_d = ~ack_tgl_q;
               mst_d = M_IDLE;
            end
         end
         default: mst_d = M_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      rq_q <= rq_d;
      ws_q <= ws_d;
      if (sys_rst) begin
         rqlvl_q <= 1'b0;
         wlvl_q <= 1'b0;
         seen_q <= 1'b0;
         ack_tgl_q <= 1'b0;
         valid_q <= 1'b0;
         halt_q <= 1'b0;
         step_q <= 1'b0;
         cmd_q <= '0;
         result_q <= 32'h0000_0000;
         mst_q <= M_IDLE;
      end else begin
         rqlvl_q <= rqlvl_d;
         wlvl_q <= wlvl_d;
         seen_q <= seen_d;
         ack_tgl_q <= ack_tgl_d;
         valid_q <= valid_d;
         halt_q <= halt_d;
         step_q <= step_d;
         cmd_q <= cmd_d;
         result_q <= result_d;
         mst_q <= mst_d;
      end
   end

   assign bus_valid = valid_q;
   assign bus_cmd = cmd_q;
   assign cpu_halt_req = halt_q;
   assign cpu_step = step_q;
   assign wire_mode = wlvl_q;
endmodule

// ### tb/swj_debug_tap_chain_chk.sv
// Port assertions for the wire/JTAG debug port
`timescale 1ns/1ps
module swj_debug_tap_chain_chk
   import debug_port_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic jtag_clock_pin,
   input wire logic jtag_mode_select_pin,
   input wire logic jtag_mode_select_out,
   input wire logic jtag_mode_select_oe,
   input wire logic jtag_data_in_pin,
   input wire logic jtag_data_out_pin,
   input wire logic jtag_data_out_oe,
   input wire logic jtag_reset_n_pin,
   input wire logic bus_valid,
   input wire bus_cmd_t bus_cmd,
   input wire logic bus_ack,
   input wire logic [31:0] bus_rdata,
   input wire logic cpu_halted,
   input wire logic cpu_halt_req,
   input wire logic cpu_step,
   input wire logic wire_mode
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   a_valid_hold: assert property (bus_valid && !bus_ack |=> bus_valid)
      else $error("bus request dropped before ack");
   a_cmd_stable: assert property (bus_valid && !bus_ack |=>
      $stable(bus_cmd))
      else $error("bus command changed while waiting");
   a_valid_drop: assert property (bus_valid && bus_ack |=> !bus_valid)
      else $error("bus request held after ack");
   a_step_pulse: assert property (cpu_step |=> !cpu_step)
      else $error("step longer than one cycle");
   a_reset_quiet: assert property (disable iff (1'h0) sys_rst |=>
      !bus_valid && !cpu_halt_req && !cpu_step && !wire_mode)
      else $error("outputs active after reset");
   a_pin_input: assert property (!jtag_mode_select_oe)
      else $error("mode-select pin driven");
   a_mode_settle: assert property ($changed(wire_mode) |=>
      $stable(wire_mode) [*8])
      else $error("mode flag toggled too fast");
   a_tdo_fall: assert property (@(jtag_clock_pin)
      $changed(jtag_data_out_pin) |-> !jtag_clock_pin)
      else $error("data out moved while link clock high");
   a_oe_fall: assert property (@(jtag_clock_pin)
      $changed(jtag_data_out_oe) |-> !jtag_clock_pin)
      else $error("data out enable moved while clock high");
   c_write: cover property (bus_valid && bus_ack && bus_cmd.write);
   c_read: cover property (bus_valid && bus_ack && !bus_cmd.write);
   c_step: cover property (cpu_step);
   c_wire: cover property ($rose(wire_mode));
endmodule

// ### tb/probe_model.sv
// Debug tool model driving the shared JTAG pins
`timescale 1ns/1ps
module probe_model (
   output logic tck,
   output logic tms,
   output logic tdi,
   output logic trst_n,
   input wire logic tdo
);
   initial begin
      tck = 1'h0;
      tms = 1'h1;
      tdi = 1'h0;
      trst_n = 1'h1;
   end
   // One link bit; clock stands low between frames
   task automatic bit1(input logic t, input logic d, output logic o);
      tms = t;
      tdi = d;
      #80;
      o = tdo;
      tck = 1'h1;
      #80;
      tck = 1'h0;
   endtask
   task automatic idle(input logic t, input int n);
      logic o;
      for (int i = 0; i < n; i++) bit1(t, 1'h0, o);
   endtask
   task automatic scan(input logic ir, input int n, input logic [63:0] din,
         output logic [63:0] dout);
      logic o;
      dout = '0;
      bit1(1'h1, 1'h0, o);
      if (ir) bit1(1'h1, 1'h0, o);
      bit1(1'h0, 1'h0, o);
      bit1(1'h0, 1'h0, o);
      for (int i = 0; i < n; i++) begin
         bit1(i == n - 1, din[i], o);
         dout[i] = o;
      end
      bit1(1'h1, 1'h0, o);
      bit1(1'h0, 1'h0, o);
   endtask
   task automatic seq16(input logic [15:0] s);
      logic o;
      idle(1'h1, 56);
      for (int i = 0; i < 16; i++) bit1(s[i], 1'h0, o);
      idle(1'h1, 56);
      idle(1'h0, 1);
   endtask
   task automatic pin_reset();
      trst_n = 1'h0;
      idle(1'h1, 6);
      trst_n = 1'h1;
      idle(1'h1, 5);
      idle(1'h0, 1);
   endtask
endmodule

// ### tb/swj_debug_tap_chain_test.sv
// Self-checking bench for the wire/JTAG debug port
`timescale 1ns/1ps
module swj_debug_tap_chain_test;
   import debug_port_pkg::*;
   logic mclk, sys_rst, bus_ack, cpu_halted, bus_valid, halt_req, step;
   logic tck, tms_drv, tms_w, tdi, trst_n, tdo, tdo_oe, sw_out, sw_oe;
   logic wire_mode;
   logic [31:0] bus_rdata;
   logic [63:0] q;
   bus_cmd_t bus_cmd, last_cmd;
   int n_errors, samples_checked, ack_dly, cnt, n_xfer, n_step, k;

   assign tms_w = sw_oe ? sw_out : tms_drv;
   initial begin
      mclk = 1'h0;
      forever #10 mclk = ~mclk;
   end
   probe_model u_probe (.tck(tck), .tms(tms_drv), .tdi(tdi),
      .trst_n(trst_n), .tdo(tdo_oe ? tdo : ~tdo));
   swj_debug_tap_chain u_dut (.mclk(mclk), .sys_rst(sys_rst),
      .jtag_clock_pin(tck), .jtag_mode_select_pin(tms_w),
      .jtag_mode_select_out(sw_out), .jtag_mode_select_oe(sw_oe),
      .jtag_data_in_pin(tdi), .jtag_data_out_pin(tdo),
      .jtag_data_out_oe(tdo_oe), .jtag_reset_n_pin(trst_n),
      .bus_valid(bus_valid), .bus_cmd(bus_cmd), .bus_ack(bus_ack),
      .bus_rdata(bus_rdata), .cpu_halted(cpu_halted),
      .cpu_halt_req(halt_req), .cpu_step(step), .wire_mode(wire_mode));
   // Bus slave with adjustable stall; idle data keeps moving
   always @(posedge mclk) begin
      #1;
      if (bus_valid && !bus_ack) begin
         cnt = cnt + 1;
         if (cnt >= ack_dly) begin
            bus_ack = 1'h1;
            bus_rdata = bus_cmd.addr ^ 32'h5A5A_0000;
            last_cmd = bus_cmd;
            n_xfer++;
            cnt = 0;
         end
      end else begin
         bus_ack = 1'h0;
         bus_rdata = ~bus_rdata;
      end
      cpu_halted = halt_req;
      if (step === 1'h1) n_step++;
   end
   task automatic chk(input string nm, input logic [71:0] e,
         input logic [71:0] g);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic ap(input logic [1:0] a, input logic rd,
         input logic [31:0] d);
      u_probe.scan(1'h0, 36, {29'h0, d, a, rd}, q);
   endtask
   task automatic t_chain();
      u_probe.scan(1'h0, 64, 64'h0, q);
      chk("idcode chain", {TEST_IDCODE, CPU_IDCODE}, q);
      u_probe.scan(1'h1, 8, {IR_BYPASS, IR_BYPASS}, q);
      chk("ir capture", 8'h11, q);
      u_probe.scan(1'h0, 8, 64'hA5, q);
      chk("two bypass bits", 8'h94, q);
      u_probe.pin_reset();
      u_probe.scan(1'h0, 64, 64'h0, q);
      chk("idcode after pin reset", {TEST_IDCODE, CPU_IDCODE}, q);
      $display("t_chain done");
   endtask
   task automatic t_access();
      u_probe.scan(1'h1, 8, {IR_BYPASS, IR_IDCODE}, q);
      u_probe.scan(1'h0, 33, 64'h0, q);
      chk("cpu idcode via bypass", CPU_IDCODE, q);
      u_probe.scan(1'h1, 8, {IR_BYPASS, IR_APACC}, q);
      ap(AP_ADDR, 1'h0, 32'h2000_0040);
      ap(AP_DATA, 1'h0, 32'hCAFE_0001);
      u_probe.idle(1'h0, 8);
      chk("write cmd", {1'h1, 32'h2000_0040, 32'hCAFE_0001}, last_cmd);
      ap(AP_DATA, 1'h1, 32'h0);
      u_probe.idle(1'h0, 8);
      ap(AP_STAT, 1'h1, 32'h0);
      chk("read posted", {32'h7A5A_0040, ACK_OK}, q[34:0]);
      u_probe.idle(1'h0, 8);
      ap(AP_CTRL, 1'h0, 32'h1);
      u_probe.idle(1'h0, 8);
      chk("halt request", 1'h1, halt_req);
      ap(AP_STAT, 1'h1, 32'h0);
      u_probe.idle(1'h0, 8);
      k = n_step;
      ap(AP_CTRL, 1'h0, 32'h3);
      chk("status halted", {32'h1, ACK_OK}, q[34:0]);
      u_probe.idle(1'h0, 8);
      chk("one step pulse", 1, n_step - k);
      $display("t_access done");
   endtask
   task automatic t_refuse();
      ack_dly = 150;
      k = n_xfer;
      ap(AP_DATA, 1'h0, 32'h0BAD_0002);
      ap(AP_DATA, 1'h0, 32'h0BAD_0003);
      chk("busy wait ack", {32'h0, ACK_WAIT}, q[34:0]);
      u_probe.idle(1'h0, 30);
      chk("one transfer only", 1, n_xfer - k);
      chk("kept data", 32'h0BAD_0002, last_cmd.wdata);
      ack_dly = 2;
      u_probe.scan(1'h1, 8, {IR_BYPASS, IR_DPACC}, q);
      u_probe.scan(1'h0, 36, 64'h0, q);
      chk("dp status idle", {32'h0, ACK_OK}, q[34:0]);
      $display("t_refuse done");
   endtask
   task automatic t_mode();
      u_probe.seq16(SEQ_TO_WIRE);
      chk("wire selected", 1'h1, wire_mode);
      u_probe.seq16(SEQ_TO_JTAG);
      chk("jtag selected", 1'h0, wire_mode);
      u_probe.scan(1'h0, 64, 64'h0, q);
      chk("chain restored", {TEST_IDCODE, CPU_IDCODE}, q);
      chk("wire data pin idle", 2'h0, {sw_out, sw_oe});
      $display("t_mode done");
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      sys_rst = 1'h1;
      bus_ack = 1'h0;
      bus_rdata = 32'h0;
      cpu_halted = 1'h0;
      n_errors = 0;
      samples_checked = 0;
      ack_dly = 2;
      cnt = 0;
      n_xfer = 0;
      n_step = 0;
      u_probe.idle(1'h1, 6);
      @(posedge mclk);
      #1 sys_rst = 1'h0;
      u_probe.idle(1'h1, 5);
      u_probe.idle(1'h0, 1);
      t_chain();
      t_access();
      t_refuse();
      t_mode();
      end_sim();
   end
endmodule
bind swj_debug_tap_chain swj_debug_tap_chain_chk u_chk (
   .mclk(mclk),
   .sys_rst(sys_rst),
   .jtag_clock_pin(jtag_clock_pin),
   .jtag_mode_select_pin(jtag_mode_select_pin),
   .jtag_mode_select_out(jtag_mode_select_out),
   .jtag_mode_select_oe(jtag_mode_select_oe),
   .jtag_data_in_pin(jtag_data_in_pin),
   .jtag_data_out_pin(jtag_data_out_pin),
   .jtag_data_out_oe(jtag_data_out_oe),
   .jtag_reset_n_pin(jtag_reset_n_pin),
   .bus_valid(bus_valid),
   .bus_cmd(bus_cmd),
   .bus_ack(bus_ack),
   .bus_rdata(bus_rdata),
   .cpu_halted(cpu_halted),
   .cpu_halt_req(cpu_halt_req),
   .cpu_step(cpu_step),
   .wire_mode(wire_mode)
);
